// ### src/uart_pkg.sv
// shared register map, timing points and state types for the serial frame engine
package uart_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [1:0] OFS_CONTROL = 2'h0;
  localparam logic [1:0] OFS_BUFFER = 2'h1;
  localparam logic [1:0] OFS_POWER = 2'h2;

  // serial_control_reg fields
  localparam int CTL_RECEIVE_DONE = 0;
  localparam int CTL_TRANSMIT_DONE = 1;
  localparam int CTL_NINTH_BIT = 2;
  localparam int CTL_RECEIVE_ENABLE = 4;
  localparam int CTL_MULTIPROC = 5;
  localparam int CTL_MODE_ASYNC = 6;

  // power_control_reg fields
  localparam int PWR_BAUD_DOUBLER = 7;

  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================================
  // machine cycle: six states of two phases, one phase per clock
  // ==========================================================================
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P1 = 4'ha;
  localparam logic [3:0] PH_S6P2 = 4'hb;
  localparam logic [3:0] PH_LAST = 4'hb;

  // ==========================================================================
  // divide-by-16 bit timing
  // ==========================================================================
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_7TH = 4'h6;
  localparam logic [3:0] SAMPLE_8TH = 4'h7;
  localparam logic [3:0] SAMPLE_9TH = 4'h8;

  // ==========================================================================
  // shift register patterns
  // ==========================================================================
  localparam logic [7:0] TX_END_PATTERN = 8'h01;
  // 11111110 seen from the far end of a right-moving register
  localparam logic [7:0] RX_SHIFT_INIT = 8'h7f;
  localparam logic [8:0] RX_FRAME_INIT = 9'h1ff;

  // ==========================================================================
  // state types
  // ==========================================================================
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_REQ = 3'b001,
    TX_WAIT = 3'b011,
    TX_START = 3'b010,
    TX_SEND = 3'b110,
    TX_LAST = 3'b111
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_ARM = 3'b001,
    RX_PREP = 3'b011,
    RX_RUN = 3'b010,
    RX_DONE = 3'b110
  } rx_state_t;

endpackage

// ### src/uart_shift_and_async_frame_engine.sv
// serial port engine: synchronous shift mode and asynchronous 10-bit frame mode
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps

module uart_shift_and_async_frame_engine #(
  parameter int ADDR_W = 2,
  parameter int DATA_W = 8
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic timer1_overflow_in,
  input wire logic shift_data_pin_in,
  output logic shift_data_pin_out,
  output logic shift_data_pin_oe_out,
  output logic shift_clock_pin_out
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic [3:0] phase;
  logic mode_async;
  logic rx_enable;
  logic multiproc_filter_bit;
  logic received_ninth_bit;
  logic transmit_done_flag;
  logic receive_done_flag;
  logic baud_doubler_bit;
  logic [DATA_W-1:0] serial_buffer;
  logic [8:0] tx_shift;
  logic tx_data_on;
  uart_pkg::tx_state_t tx_state;
  uart_pkg::rx_state_t rx_state;
  logic [8:0] rx_shift;
  logic rx_first;
  logic [3:0] rx_cnt;
  logic [3:0] tx_cnt;
  logic samp_a;
  logic samp_b;
  logic pin_sample;
  logic data_meta;
  logic data_sync;
  logic data_prev_tick;
  logic tick_half;
  logic tick16;

  logic wr_ctrl;
  logic wr_buf;
  logic wr_pwr;
  logic at_s1p1;
  logic at_s5p2;
  logic at_s6p2;
  logic tx_roll;
  logic vote;
  logic rx_vote_now;
  logic rx_final_async;
  logic rx_accept_async;
  logic rx_done_shift;
  logic tx_done_set;
  logic rx_done_set;
  logic shift_active;
  logic next_clock_level;
  logic [3:0] next_phase;
  logic tx_sending;

  // ==========================================================================
  // decode and timing points
  // ==========================================================================
  assign wr_ctrl = reg_write_in && (reg_addr_in == uart_pkg::OFS_CONTROL);
  assign wr_buf = reg_write_in && (reg_addr_in == uart_pkg::OFS_BUFFER);
  assign wr_pwr = reg_write_in && (reg_addr_in == uart_pkg::OFS_POWER);

  assign at_s1p1 = (phase == uart_pkg::PH_S1P1);
  assign at_s5p2 = (phase == uart_pkg::PH_S5P2);
  assign at_s6p2 = (phase == uart_pkg::PH_S6P2);

  assign tx_roll = tick16 && (tx_cnt == uart_pkg::DIV16_LAST);

  assign vote = (samp_a & samp_b) | (samp_a & data_sync) | (samp_b & data_sync);
  assign rx_vote_now = mode_async && (rx_state == uart_pkg::RX_RUN) && tick16 &&
                       (rx_cnt == uart_pkg::SAMPLE_9TH);
  // start bit has reached the far end: this vote is the stop bit
  assign rx_final_async = rx_vote_now && !rx_first && !rx_shift[0];
  assign rx_accept_async = rx_final_async && !receive_done_flag &&
                           (!multiproc_filter_bit || vote);
  assign rx_done_shift = !mode_async && (rx_state == uart_pkg::RX_RUN) && at_s6p2 &&
                         !rx_shift[0];

  assign tx_done_set = (!mode_async && (tx_state == uart_pkg::TX_LAST) && at_s1p1) ||
                       (mode_async && (tx_state == uart_pkg::TX_SEND) && tx_roll &&
                        (tx_shift[8:1] == uart_pkg::TX_END_PATTERN));
  assign rx_done_set = rx_accept_async ||
                       (!mode_async && (rx_state == uart_pkg::RX_DONE) && at_s1p1);

  assign shift_active = (tx_state == uart_pkg::TX_SEND) || (tx_state == uart_pkg::TX_LAST) ||
                        (rx_state == uart_pkg::RX_RUN) || (rx_state == uart_pkg::RX_DONE);
  assign tx_sending = (tx_state == uart_pkg::TX_SEND) || (tx_state == uart_pkg::TX_LAST);
  assign next_phase = (phase == uart_pkg::PH_LAST) ? uart_pkg::PH_S1P1 : phase + 4'h1;
  // taken from the coming phase so the registered pin is low exactly from S3P1 to the end of S5
  assign next_clock_level = !((next_phase >= uart_pkg::PH_S3P1) && (next_phase < uart_pkg::PH_S6P1));

  // ==========================================================================
  // machine cycle phase counter
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      phase <= uart_pkg::PH_S1P1;
    end else if (phase == uart_pkg::PH_LAST) begin
      phase <= uart_pkg::PH_S1P1;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // ==========================================================================
  // pin synchroniser
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      data_meta <= 1'b1;
      data_sync <= 1'b1;
    end else begin
      data_meta <= shift_data_pin_in;
      data_sync <= data_meta;
    end
  end

  // ==========================================================================
  // 16x tick from timer 1 overflow
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tick_half <= 1'b0;
      tick16 <= 1'b0;
    end else begin
      if (timer1_overflow_in) begin
        tick_half <= !tick_half;
      end
      // doubler clear: only every second overflow counts
      tick16 <= timer1_overflow_in && (baud_doubler_bit || tick_half);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_cnt <= 4'h0;
    end else if (tick16) begin
      tx_cnt <= tx_cnt + 4'h1;
    end
  end

  // ==========================================================================
  // control and power registers
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      mode_async <= 1'b0;
      rx_enable <= 1'b0;
      multiproc_filter_bit <= 1'b0;
      baud_doubler_bit <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_async <= reg_wdata_in[uart_pkg::CTL_MODE_ASYNC];
        rx_enable <= reg_wdata_in[uart_pkg::CTL_RECEIVE_ENABLE];
        multiproc_filter_bit <= reg_wdata_in[uart_pkg::CTL_MULTIPROC];
      end
      if (wr_pwr) begin
        baud_doubler_bit <= reg_wdata_in[uart_pkg::PWR_BAUD_DOUBLER];
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      transmit_done_flag <= 1'b0;
    end else if (tx_done_set) begin
      transmit_done_flag <= 1'b1;
    end else if (wr_ctrl) begin
      transmit_done_flag <= reg_wdata_in[uart_pkg::CTL_TRANSMIT_DONE];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      receive_done_flag <= 1'b0;
    end else if (rx_done_set) begin
      receive_done_flag <= 1'b1;
    end else if (wr_ctrl) begin
      receive_done_flag <= reg_wdata_in[uart_pkg::CTL_RECEIVE_DONE];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      received_ninth_bit <= 1'b0;
    end else if (rx_accept_async) begin
      received_ninth_bit <= vote;
    end else if (wr_ctrl) begin
      received_ninth_bit <= reg_wdata_in[uart_pkg::CTL_NINTH_BIT];
    end
  end

  // ==========================================================================
  // register read port, data one cycle after the strobe
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= uart_pkg::READ_ZERO;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        uart_pkg::OFS_CONTROL: begin
          reg_rdata_out <= uart_pkg::READ_ZERO;
          reg_rdata_out[uart_pkg::CTL_MODE_ASYNC] <= mode_async;
          reg_rdata_out[uart_pkg::CTL_RECEIVE_ENABLE] <= rx_enable;
          reg_rdata_out[uart_pkg::CTL_MULTIPROC] <= multiproc_filter_bit;
          reg_rdata_out[uart_pkg::CTL_NINTH_BIT] <= received_ninth_bit;
          reg_rdata_out[uart_pkg::CTL_TRANSMIT_DONE] <= transmit_done_flag;
          reg_rdata_out[uart_pkg::CTL_RECEIVE_DONE] <= receive_done_flag;
        end
        uart_pkg::OFS_BUFFER: begin
          reg_rdata_out <= serial_buffer;
        end
        uart_pkg::OFS_POWER: begin
          reg_rdata_out <= uart_pkg::READ_ZERO;
          reg_rdata_out[uart_pkg::PWR_BAUD_DOUBLER] <= baud_doubler_bit;
        end
        default: begin
          reg_rdata_out <= uart_pkg::READ_ZERO;
        end
      endcase
    end else begin
      reg_rdata_out <= uart_pkg::READ_ZERO;
    end
  end

  // ==========================================================================
  // transmitter
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_state <= uart_pkg::TX_IDLE;
      tx_shift <= 9'h000;
      tx_data_on <= 1'b0;
    end else if (wr_buf) begin
      tx_shift <= {1'b1, reg_wdata_in};
      tx_data_on <= 1'b0;
      tx_state <= uart_pkg::TX_REQ;
    end else begin
      unique case (tx_state)
        uart_pkg::TX_IDLE: begin
          tx_data_on <= 1'b0;
        end
        uart_pkg::TX_REQ: begin
          // shift mode: go to TX_WAIT and start at the first S6P2 seen there, as soon as two clocks after the write
          if (!mode_async) begin
            tx_state <= uart_pkg::TX_WAIT;
          end else if (mode_async && tx_roll) begin
            tx_state <= uart_pkg::TX_WAIT;
          end
        end
        uart_pkg::TX_WAIT: begin
          if (!mode_async && at_s6p2) begin
            tx_state <= uart_pkg::TX_SEND;
          end else if (mode_async && at_s1p1) begin
            tx_state <= uart_pkg::TX_START;
          end
        end
        uart_pkg::TX_START: begin
          if (tx_roll) begin
            tx_data_on <= 1'b1;
            tx_state <= uart_pkg::TX_SEND;
          end
        end
        uart_pkg::TX_SEND: begin
          if (!mode_async && at_s6p2) begin
            tx_shift <= {1'b0, tx_shift[8:1]};
            if (tx_shift[8:1] == uart_pkg::TX_END_PATTERN) begin
              tx_state <= uart_pkg::TX_LAST;
            end
          end else if (mode_async && tx_roll) begin
            tx_shift <= {1'b0, tx_shift[8:1]};
            if (tx_shift[8:1] == uart_pkg::TX_END_PATTERN) begin
              tx_data_on <= 1'b0;
              tx_state <= uart_pkg::TX_IDLE;
            end
          end
        end
        uart_pkg::TX_LAST: begin
          if (at_s1p1) begin
            tx_state <= uart_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state <= uart_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // receiver
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      data_prev_tick <= 1'b1;
      samp_a <= 1'b1;
      samp_b <= 1'b1;
      pin_sample <= 1'b1;
    end else begin
      if (tick16) begin
        data_prev_tick <= data_sync;
      end
      if (tick16 && (rx_cnt == uart_pkg::SAMPLE_7TH)) begin
        samp_a <= data_sync;
      end
      if (tick16 && (rx_cnt == uart_pkg::SAMPLE_8TH)) begin
        samp_b <= data_sync;
      end
      if (at_s5p2) begin
        pin_sample <= data_sync;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rx_state <= uart_pkg::RX_IDLE;
      rx_shift <= uart_pkg::RX_FRAME_INIT;
      rx_first <= 1'b0;
      rx_cnt <= 4'h0;
      serial_buffer <= 8'h00;
    end else begin
      if (tick16) begin
        rx_cnt <= rx_cnt + 4'h1;
      end
      unique case (rx_state)
        uart_pkg::RX_IDLE: begin
          if (mode_async && rx_enable && tick16 && data_prev_tick && !data_sync) begin
            rx_cnt <= 4'h0;
            rx_shift <= uart_pkg::RX_FRAME_INIT;
            rx_first <= 1'b1;
            rx_state <= uart_pkg::RX_RUN;
          end else if (!mode_async && rx_enable && !receive_done_flag) begin
            rx_state <= uart_pkg::RX_ARM;
          end
        end
        uart_pkg::RX_ARM: begin
          if (at_s1p1) begin
            rx_state <= uart_pkg::RX_PREP;
          end
        end
        uart_pkg::RX_PREP: begin
          if (at_s6p2) begin
            rx_shift <= {1'b1, uart_pkg::RX_SHIFT_INIT};
            rx_state <= uart_pkg::RX_RUN;
          end
        end
        uart_pkg::RX_RUN: begin
          if (!mode_async) begin
            if (at_s6p2) begin
              rx_shift <= {1'b1, pin_sample, rx_shift[7:1]};
              if (rx_done_shift) begin
                serial_buffer <= {pin_sample, rx_shift[7:1]};
                rx_state <= uart_pkg::RX_DONE;
              end
            end
          end else if (rx_vote_now) begin
            if (rx_first && vote) begin
              rx_state <= uart_pkg::RX_IDLE;
            end else if (rx_final_async) begin
              if (rx_accept_async) begin
                serial_buffer <= rx_shift[8:1];
              end
              rx_shift <= uart_pkg::RX_FRAME_INIT;
              rx_state <= uart_pkg::RX_IDLE;
            end else begin
              rx_shift <= {vote, rx_shift[8:1]};
              rx_first <= 1'b0;
            end
          end
        end
        uart_pkg::RX_DONE: begin
          if (at_s1p1) begin
            rx_state <= uart_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state <= uart_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // pin drivers
  // ==========================================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      shift_data_pin_out <= 1'b1;
      shift_data_pin_oe_out <= 1'b0;
      shift_clock_pin_out <= 1'b1;
    end else if (!mode_async) begin
      // shift mode: data pin driven only while sending, clock pin is shift clock
      shift_data_pin_oe_out <= tx_sending;
      shift_data_pin_out <= tx_sending ? tx_shift[0] : 1'b1;
      shift_clock_pin_out <= shift_active ? next_clock_level : 1'b1;
    end else begin
      // frame mode: data pin is the receive input, clock pin is the transmit line
      shift_data_pin_oe_out <= 1'b0;
      shift_data_pin_out <= 1'b1;
      if (tx_state == uart_pkg::TX_START) begin
        shift_clock_pin_out <= 1'b0;
      end else if ((tx_state == uart_pkg::TX_SEND) && tx_data_on) begin
        shift_clock_pin_out <= tx_shift[0];
      end else begin
        shift_clock_pin_out <= 1'b1;
      end
    end
  end

endmodule // uart_shift_and_async_frame_engine

// ### testbench/uart_engine_sva.sv
// port checks for the serial frame engine
`timescale 1ns/100ps
module uart_engine_sva #(
  parameter int ADDR_W = 2,
  parameter int DATA_W = 8
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic timer1_overflow_in,
  input wire logic shift_data_pin_in,
  input wire logic shift_data_pin_out,
  input wire logic shift_data_pin_oe_out,
  input wire logic shift_clock_pin_out
);
  // ====================
  // phase, mode and clock edge bookkeeping
  // ====================
  logic [3:0] ph;
  logic async;
  logic [3:0] rises;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clock_in) begin
    ph <= (!rst_n_in || ph == uart_pkg::PH_LAST) ? uart_pkg::PH_S1P1 : ph + 4'h1;
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) async <= 1'b0;
    else if (reg_write_in && reg_addr_in == uart_pkg::OFS_CONTROL) async <= reg_wdata_in[uart_pkg::CTL_MODE_ASYNC];
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !shift_data_pin_oe_out) rises <= 4'h0;
    else if ($rose(shift_clock_pin_out)) rises <= rises + 4'h1;
  end
  // ====================
  // assertions
  // ====================
  sequence s_unmapped_read;
    reg_read_in && reg_addr_in == 2'h3;
  endsequence
  AST_RDATA_QUIET: assert property (!reg_read_in |=> reg_rdata_out == uart_pkg::READ_ZERO)
    else $error("read data not idle");
  AST_UNMAPPED_READ: assert property (s_unmapped_read |=> reg_rdata_out == uart_pkg::READ_ZERO)
    else $error("unmapped read not zero");
  AST_FRAME_NO_DRIVE: assert property (async |-> !shift_data_pin_oe_out)
    else $error("data pin driven in frame mode");
  AST_SEND_START: assert property ($rose(shift_data_pin_oe_out) |-> $past(ph) == uart_pkg::PH_S1P1)
    else $error("send began off the cycle boundary");
  AST_BIT_ADVANCE: assert property (shift_data_pin_oe_out && $past(shift_data_pin_oe_out)
    && $changed(shift_data_pin_out) |-> $past(ph) == uart_pkg::PH_S1P1)
    else $error("data bit changed off the shift point");
  AST_CLOCK_LOW: assert property (shift_data_pin_oe_out && ph >= uart_pkg::PH_S3P1
    && ph < uart_pkg::PH_S6P1 |-> !shift_clock_pin_out)
    else $error("shift clock high in low window");
  AST_CLOCK_HIGH: assert property (!async && (ph >= uart_pkg::PH_S6P1 || ph < uart_pkg::PH_S3P1)
    |-> shift_clock_pin_out)
    else $error("shift clock low in high window");
  AST_EIGHT_BITS: assert property ($fell(shift_data_pin_oe_out) |-> rises == 4'h8)
    else $error("send did not give eight clocks");
  AST_PIN_RELEASED: assert property (!shift_data_pin_oe_out [*2] |-> shift_data_pin_out)
    else $error("released data pin not high");
endmodule // uart_engine_sva
bind uart_shift_and_async_frame_engine uart_engine_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) sva_i (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .timer1_overflow_in(timer1_overflow_in), .shift_data_pin_in(shift_data_pin_in),
  .shift_data_pin_out(shift_data_pin_out), .shift_data_pin_oe_out(shift_data_pin_oe_out),
  .shift_clock_pin_out(shift_clock_pin_out));

// ### testbench/serial_peer_model.sv
// far-side peer: shift partner and frame sender and receiver
`timescale 1ns/100ps
module serial_peer_model #(
  parameter int BIT_CLOCKS = 64
) (
  input wire logic clock_in,
  input wire logic sclk_in,
  input wire logic dout_in,
  input wire logic oe_in,
  output logic line_out
);
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic drv;
  logic sclk_d;
  initial begin
    rx_byte = 8'h00;
    tx_byte = 8'hff;
    drv = 1'b1;
    sclk_d = 1'b1;
  end
  // pin has a pull-up: released by the engine it reads 1 unless the peer pulls it low
  assign line_out = oe_in ? dout_in : (drv & tx_byte[0]);
  always @(posedge clock_in) begin
    sclk_d <= sclk_in;
    if (sclk_in && !sclk_d && oe_in) rx_byte <= {dout_in, rx_byte[7:1]};
    else if (sclk_in && !sclk_d) tx_byte <= {1'b1, tx_byte[7:1]};
  end
  task automatic load(input logic [7:0] v);
    tx_byte <= v;
  endtask
  // optional short low pulse ahead of the frame
  task automatic send_frame(input logic [7:0] v, input logic stop, input logic glitch);
    logic [9:0] fr;
    fr = {stop, v, 1'b0};
    if (glitch) begin
      drv <= 1'b0;
      repeat (8) @(posedge clock_in);
    end
    drv <= 1'b1;
    repeat (BIT_CLOCKS) @(posedge clock_in);
    for (int i = 0; i < 10; i++) begin
      drv <= fr[i];
      repeat (BIT_CLOCKS) @(posedge clock_in);
    end
    drv <= 1'b1;
  endtask
  task automatic recv_frame(output logic [9:0] fr);
    @(posedge clock_in);
    while (sclk_in) @(posedge clock_in);
    repeat (BIT_CLOCKS / 2) @(posedge clock_in);
    for (int i = 0; i < 10; i++) begin
      fr[i] = sclk_in;
      if (i < 9) repeat (BIT_CLOCKS) @(posedge clock_in);
    end
  endtask
endmodule // serial_peer_model

// ### testbench/uart_shift_and_async_frame_engine_test.sv
// self-checking bench for the serial frame engine
`timescale 1ns/100ps
module uart_shift_and_async_frame_engine_test;
  // ====================
  // design, peer, clock and timer
  // ====================
  logic clock_in, rst_n_in, reg_write_in, reg_read_in, timer1_overflow_in, sdo, soe, sclk, line;
  logic [1:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, b;
  logic [3:0] ph;
  logic [1:0] tdiv;
  logic [9:0] f;
  int num_errors, checked;
  uart_shift_and_async_frame_engine dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .timer1_overflow_in(timer1_overflow_in), .shift_data_pin_in(line),
    .shift_data_pin_out(sdo), .shift_data_pin_oe_out(soe), .shift_clock_pin_out(sclk));
  serial_peer_model peer (.clock_in(clock_in), .sclk_in(sclk), .dout_in(sdo), .oe_in(soe), .line_out(line));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    ph <= (!rst_n_in || ph == 4'hb) ? 4'h0 : ph + 4'h1;
    tdiv <= tdiv + 2'h1;
    timer1_overflow_in <= (tdiv == 2'h3);
  end
  // ====================
  // tasks
  // ====================
  // f: mode, filter, enable, ninth bit, transmit done, receive done
  function automatic logic [7:0] ctl(input logic [5:0] f);
    ctl = {1'b0, f[5:3], 1'b0, f[2:0]};
  endfunction
  task automatic check_value(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 check_value(reg_rdata_out, exp);
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ====================
  // sequence and watchdog
  // ====================
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
  initial begin
    {rst_n_in, reg_write_in, reg_read_in, timer1_overflow_in, tdiv, reg_addr_in} = '0;
    {reg_wdata_in, num_errors, checked} = '0;
    void'($urandom(79));
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    repeat (3) begin
      b = 8'($urandom);
      do @(posedge clock_in); while (ph != 4'h9);
      wr(2'h1, b);
      repeat (99) @(posedge clock_in);
      rd(2'h0, ctl(6'h00));
      repeat (12) @(posedge clock_in);
      rd(2'h0, ctl(6'h02));
      check_value(peer.rx_byte, b);
      wr(2'h0, 8'h00);
    end
    b = 8'($urandom);
    peer.load(b);
    do @(posedge clock_in); while (ph != 4'h3);
    wr(2'h0, ctl(6'h08));
    repeat (99) @(posedge clock_in);
    rd(2'h0, ctl(6'h08));
    repeat (24) @(posedge clock_in);
    rd(2'h0, ctl(6'h09));
    rd(2'h1, b);
    wr(2'h0, 8'h00);
    wr(2'h2, 8'h80);
    rd(2'h2, 8'h80);
    wr(2'h0, ctl(6'h28));
    b = 8'($urandom);
    wr(2'h1, b);
    peer.recv_frame(f);
    check_value(f[8:1], b);
    check_value({6'h00, f[9], f[0]}, 8'h02);
    rd(2'h0, ctl(6'h2a));
    wr(2'h0, ctl(6'h28));
    b = 8'($urandom);
    peer.send_frame(b, 1'b1, 1'b1);
    rd(2'h0, ctl(6'h2d));
    rd(2'h1, b);
    peer.send_frame(~b, 1'b1, 1'b0);
    rd(2'h1, b);
    wr(2'h0, ctl(6'h38));
    b = 8'($urandom);
    peer.send_frame(b, 1'b0, 1'b0);
    rd(2'h0, ctl(6'h38));
    peer.send_frame(b, 1'b1, 1'b0);
    rd(2'h0, ctl(6'h3d));
    rd(2'h1, b);
    stop_test();
  end
endmodule // uart_shift_and_async_frame_engine_test
